// ==== hw/lss_pkg.sv ====
// Constants shared by the low-side switch control logic
package lss_pkg;
   localparam int unsigned NUM_CH        = 8;      // All switch channels
   localparam int unsigned NUM_MAIN      = 6;      // Channels with serial control
   localparam int unsigned NUM_PAIRS     = 3;      // Override channel pairs
   localparam int unsigned CMD_W         = 8;      // One command byte
   localparam int unsigned CMD_MSB       = 7;      // First bit on the wire
   localparam int unsigned OL_EN_LO_BIT  = 6;      // Open-load-on enable, channels 2..0
   localparam int unsigned OL_EN_HI_BIT  = 7;      // Open-load-on enable, channels 5..3
   localparam int unsigned OL_SPLIT_CH   = 3;      // First channel under the high enable bit
   localparam int unsigned PAIR_MID_LO   = 2;      // Parallel pin feeding middle pair
   localparam int unsigned PAIR_MID_HI   = 3;      // Second parallel pin of middle pair
   localparam logic [7:0]  CMD_RST       = 8'h00;  // All serial channels off
   localparam logic [7:0]  FAULT_RST     = 8'h00;  // No faults reported
   localparam logic [7:0]  GATE_RST      = 8'h00;  // All gates inactive
   localparam logic [5:0]  MAIN_OFF      = 6'h00;  // Forced-off main gates
   localparam logic [1:0]  LOWPWR_OFF    = 2'h0;   // Forced-off low-power gates
endpackage : lss_pkg

// ==== hw/lss_shift_if.sv ====
// Carrier between the switch control and its serial shifter
`timescale 1ns/10ps
interface lss_shift_if;
   import lss_pkg::*;
   logic               shift_rise;   // Rising shift-clock edge inside a frame
   logic               shift_fall;   // Falling shift-clock edge inside a frame
   logic               frame_start;  // Select just went active
   logic               sdi;          // Synchronised serial input
   logic [CMD_W-1:0]   status;       // Frozen fault status
   logic [CMD_W-1:0]   shreg;        // Shift register contents
   logic               sdo;          // Serial output bit
   modport ctrl    (output shift_rise, output shift_fall, output frame_start, output sdi,
                    output status, input shreg, input sdo);
   modport shifter (input shift_rise, input shift_fall, input frame_start, input sdi,
                    input status, output shreg, output sdo);
endinterface : lss_shift_if

// ==== hw/lss_shifter.sv ====
// Serial shift register: status out, command in, MSB first
`timescale 1ns/10ps
module lss_shifter
   import lss_pkg::*;
(
   input  wire logic      clock_in,
   input  wire logic      nrst_in,
   lss_shift_if.shifter   sh
);
   logic [CMD_W-1:0] sr_q;
   logic             so_q;

   // Status loads at frame start; a 16-bit frame pushes the first byte back out
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sr_q <= CMD_RST;
         so_q <= 1'b0;
      end else if (sh.frame_start) begin
         sr_q <= sh.status;
         so_q <= sh.status[CMD_MSB];
      end else if (sh.shift_rise) begin
         sr_q <= {sr_q[CMD_W-2:0], sh.sdi};
      end else if (sh.shift_fall) begin
         so_q <= sr_q[CMD_MSB];
      end
   end

   assign sh.shreg = sr_q;
   assign sh.sdo   = so_q;
endmodule : lss_shifter

// ==== hw/lss_switch_ctrl.sv ====
// Eight-channel low-side switch control with serial and parallel input
`timescale 1ns/10ps
module lss_switch_ctrl
   import lss_pkg::*;
#(
   parameter int unsigned CH = NUM_CH
)
(
   input  wire logic          clock_in,
   input  wire logic          nrst_in,
   input  wire logic          sclk_in,
   input  wire logic          cs_n_in,
   input  wire logic          si_in,
   output logic               so_out,
   output logic               so_oe_out,
   input  wire logic          override_sel_in,
   input  wire logic [CH-1:0] parallel_channel_pins_in,
   input  wire logic          pair_input_low_in,
   input  wire logic          pair_input_high_in,
   input  wire logic [CH-1:0] short_fault_in,
   input  wire logic [CH-1:0] open_fault_in,
   input  wire logic          overvolt_in,
   output logic [CH-1:0]      switch_channel_pins_out,
   output logic [CH-1:0]      gate_out,
   output logic [CMD_W-1:0]   command_out,
   output logic [CH-1:0]      fault_status_out
);
   // Width of the bundle of asynchronous pins
   localparam int unsigned SW = 7 + 3 * CH;

   // Shift path signals travel to the shifter in one bundle
   lss_shift_if sh ();

   // Registers
   logic [SW-1:0]    sync1_q;
   logic [SW-1:0]    sync2_q;
   logic             sclk_d1_q;
   logic             cs_act_d1_q;
   logic [CMD_W-1:0] cmd_q;
   logic [CH-1:0]    fault_q;
   logic [CH-1:0]    gate_q;

   // Raw pin bundle and its synchronised copies
   wire  [SW-1:0]    raw_pins;
   wire              sclk_s;
   wire              cs_act_s;
   wire              si_s;
   wire              ovr_s;
   wire  [CH-1:0]    par_s;
   wire              pair_lo_s;
   wire              pair_hi_s;
   wire  [CH-1:0]    short_s;
   wire  [CH-1:0]    open_s;
   wire              ov_s;

   // Frame control and channel request path
   wire              frame_start;
   wire              fault_upd_en;
   wire              frame_end;
   wire  [NUM_PAIRS-1:0] pair_on;
   wire  [NUM_MAIN-1:0]  normal_gate;
   wire  [NUM_MAIN-1:0]  ovr_gate;
   wire  [NUM_MAIN-1:0]  main_req;
   wire  [NUM_MAIN-1:0]  ol_on_en;
   wire  [CH-1:0]        req;
   wire  [CH-1:0]        ol_en;
   wire  [CH-1:0]        fault_now;
   wire  [CH-1:0]        gate_d;
   wire  [CH-NUM_MAIN-1:0] lowpwr_req;

   // Select is inverted before the synchroniser so every stage resets to zero
   // Reset values match idle pins (select high, shift clock low), so no false edge
   // Bundle order: shift clock, select, data, override, parallel pins, pair pins,
   // short sense, open sense, overvoltage; all pass the same two stages
   assign raw_pins = {sclk_in, ~cs_n_in, si_in, override_sel_in, parallel_channel_pins_in,
                      pair_input_low_in, pair_input_high_in, short_fault_in, open_fault_in,
                      overvolt_in};

   // Two-stage synchroniser for every pin from outside the clock domain
   // Costs two clocks of latency; each shift-clock half period must span
   // more than one clock or an edge is lost
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= raw_pins;
         sync2_q <= sync1_q;
      end
   end

   // Unpack the synchronised bundle
   // Order must mirror the bundle above
   assign {sclk_s, cs_act_s, si_s, ovr_s, par_s, pair_lo_s, pair_hi_s,
           short_s, open_s, ov_s} = sync2_q;

   // Delayed copies for edge detection, taken from the second stage only
   // The first stage is never read here, which keeps metastability out
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sclk_d1_q   <= 1'b0;
         cs_act_d1_q <= 1'b0;
      end else begin
         sclk_d1_q   <= sclk_s;
         cs_act_d1_q <= cs_act_s;
      end
   end

   // Frame and shift-clock edges; shifting only while selected
   // Shift clock edges outside a frame are ignored, so a free-running clock is harmless
   assign frame_start    = cs_act_s & ~cs_act_d1_q;
   assign frame_end      = ~cs_act_s & cs_act_d1_q;
   assign sh.frame_start = frame_start;
   assign sh.shift_rise  = cs_act_s & sclk_s & ~sclk_d1_q;
   assign sh.shift_fall  = cs_act_s & ~sclk_s & sclk_d1_q;
   assign sh.sdi         = si_s;
   assign sh.status      = fault_q;

   // Status bit 7 belongs to channel 7 and leaves first
   lss_shifter u_shifter (
      .clock_in (clock_in),
      .nrst_in  (nrst_in),
      .sh       (sh)
   );

   // Command latch; it keeps loading in override so the value waits for normal mode
   // The last eight bits received win, so a 16-bit frame latches its second byte
   // Reset leaves every serially controlled channel off until the first frame ends
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cmd_q <= CMD_RST;
      end else if (frame_end) begin
         cmd_q <= sh.shreg;
      end
   end

   // Override pairs: outer pairs from dedicated pins, middle pair from its two pins
   // The middle pair has no dedicated pin; either of its parallel pins turns it on
   assign pair_on[0] = pair_lo_s;
   assign pair_on[1] = par_s[PAIR_MID_LO] | par_s[PAIR_MID_HI];
   assign pair_on[2] = pair_hi_s;

   // Per-channel request for the six main channels
   // Open-load-on detection: bit 6 covers channels 2..0, bit 7 channels 5..3
   genvar g;
   generate
      for (g = 0; g < NUM_MAIN; g++) begin : g_main
         assign normal_gate[g] = cmd_q[g] | par_s[g];
         assign ovr_gate[g]    = pair_on[g / 2];
         assign ol_on_en[g]    = (g >= OL_SPLIT_CH) ? cmd_q[OL_EN_HI_BIT]
                                                    : cmd_q[OL_EN_LO_BIT];
      end
   endgenerate

   // Override wins over serial and parallel; overvoltage wins over everything on the six main channels
   // Overvoltage sits above override because it protects the switches themselves
   assign main_req = ov_s  ? MAIN_OFF :
                     ovr_s ? ovr_gate : normal_gate;
   assign req      = {lowpwr_req, main_req};
   assign ol_en    = {LOWPWR_OFF, ol_on_en};

   // Low-power channels follow their parallel pins only; override forces them off
   assign lowpwr_req = ovr_s ? LOWPWR_OFF : par_s[CH-1:NUM_MAIN];

   // Fault sense: short while on, open/ground while off, open while on if enabled
   // Decided on the request, not the masked gate, so a shorted channel still counts as on
   assign fault_now = (req & short_s) | (~req & open_s) | (req & open_s & ol_en);

   // A shorted channel is switched off even though it stays requested
   assign gate_d = req & ~short_s;

   // Fault register reopens once select rises, even after a frame cut short
   assign fault_upd_en = ~cs_act_s;

   // Fault register only follows the channels while the device is deselected
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fault_q <= FAULT_RST;
      end else if (fault_upd_en) begin
         fault_q <= fault_now;
      end
   end

   // Registered gates keep the switch pins glitch free
   // One clock of delay is traded for switch pins that never glitch
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         gate_q <= GATE_RST;
      end else begin
         gate_q <= gate_d;
      end
   end

   // Switch pins are active low; driver enabled only when selected and not overridden
   // The output enable trails the select pin by the two synchroniser clocks
   assign switch_channel_pins_out = ~gate_q;
   assign gate_out                = gate_q;
   assign command_out             = cmd_q;
   assign fault_status_out        = fault_q;
   assign so_out                  = sh.sdo;
   assign so_oe_out               = cs_act_s & ~ovr_s;
endmodule : lss_switch_ctrl

// ==== testbench/lss_switch_ctrl_asserts.sv ====
// Port checker for the low-side switch control
`timescale 1ns/10ps
module lss_switch_ctrl_asserts
   import lss_pkg::*;
#(
   parameter int unsigned CH = NUM_CH
)
(
   input wire logic          clock_in,
   input wire logic          nrst_in,
   input wire logic          cs_n_in,
   input wire logic          override_sel_in,
   input wire logic [CH-1:0] parallel_channel_pins_in,
   input wire logic          pair_input_low_in,
   input wire logic          pair_input_high_in,
   input wire logic [CH-1:0] short_fault_in,
   input wire logic          overvolt_in,
   input wire logic          so_oe_out,
   input wire logic [CH-1:0] switch_channel_pins_out,
   input wire logic [CH-1:0] gate_out,
   input wire logic [CH-1:0] fault_status_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!nrst_in);
   // Pin inputs pass two sync stages, so antecedents span several edges
   property p_pins_inv; switch_channel_pins_out == ~gate_out; endproperty
   property p_oe_idle; cs_n_in[*4] |-> !so_oe_out; endproperty
   property p_ovr_so; override_sel_in[*4] |-> !so_oe_out; endproperty
   property p_ovr_low; override_sel_in[*5] |-> gate_out[7:6] == LOWPWR_OFF; endproperty
   property p_ovr_pair;
      (override_sel_in && pair_input_low_in && !overvolt_in && short_fault_in[1:0] == 2'h0)[*5]
         |-> gate_out[1:0] == 2'h3;
   endproperty
   property p_ovr_ign; (override_sel_in && !pair_input_high_in)[*5] |-> gate_out[5:4] == 2'h0; endproperty
   property p_ov; overvolt_in[*5] |-> gate_out[5:0] == MAIN_OFF; endproperty
   property p_or;
      (!override_sel_in && !overvolt_in && !(|short_fault_in) && &parallel_channel_pins_in)[*5]
         |-> &gate_out;
   endproperty
   property p_short; short_fault_in[0][*5] |-> !gate_out[0]; endproperty
   property p_freeze; !cs_n_in[*5] |-> $stable(fault_status_out); endproperty
   a_pins_inv: assert property (p_pins_inv) else $error("pins not inverse of gates");
   a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
   a_ovr_so: assert property (p_ovr_so) else $error("output driven in override");
   a_ovr_low: assert property (p_ovr_low) else $error("low-power gate on in override");
   a_ovr_pair: assert property (p_ovr_pair) else $error("low pair not driven");
   a_ovr_ign: assert property (p_ovr_ign) else $error("high pair on without pair input");
   a_ov: assert property (p_ov) else $error("main gate on in overvoltage");
   a_or: assert property (p_or) else $error("parallel pins not ORed in");
   a_short: assert property (p_short) else $error("shorted gate left on");
   a_freeze: assert property (p_freeze) else $error("fault status moved in frame");
   c_frame: cover property ($fell(cs_n_in));
   c_ovr: cover property (override_sel_in && pair_input_low_in);
   c_ov: cover property (overvolt_in[*5]);
endmodule : lss_switch_ctrl_asserts
bind lss_switch_ctrl lss_switch_ctrl_asserts #(.CH(CH)) chk_u (.*);

// ==== testbench/lss_host_model.sv ====
// Host model: drives select, shift clock and serial data
`timescale 1ns/10ps
module lss_host_model (
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      si_out,
   input  wire logic so_in,
   input  wire logic so_oe_in
);
   wire logic so_line;
   // A released output reads as ones through the pull-up
   assign so_line = so_oe_in ? so_in : 1'b1;
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      si_out   = 1'b0;
   end
   // One frame of n bits, MSB first, 125 ns shift period
   task automatic xfer(input logic [15:0] d, input int n, output logic [15:0] r);
      r = 16'h0000;
      cs_n_out = 1'b0;
      #0.25; // Keeps every later link edge off the clock edges
      for (int i = n - 1; i >= 0; i--) begin
         si_out = d[i];
         #62.5;
         sclk_out = 1'b1;
         r = {r[14:0], so_line};
         #62.5;
         sclk_out = 1'b0;
      end
      #62.5;
      cs_n_out = 1'b1;
      si_out = 1'b0; // Pull-down level once released
   endtask : xfer
endmodule : lss_host_model

// ==== testbench/tb_lss_switch_ctrl.sv ====
// Self-checking bench for the low-side switch control
`timescale 1ns/10ps
module tb_lss_switch_ctrl;
   import lss_pkg::*;
   typedef struct packed {logic [2:0] s; logic [15:0] v;} lss_note_t;
   `define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("unexpected at %0t got %h exp %h", $time, g, e); end end
   logic        clock_in = 1'b0, nrst_in = 1'b0, ovr = 1'b0, pl = 1'b0, ph = 1'b0, ov = 1'b0;
   logic [7:0]  par = 8'h00, shrt = 8'h00, opn = 8'h00, gate, pins, fst, cmd;
   logic        sclk, cs_n, si, so, so_oe;
   logic [15:0] rx;
   int          fails = 0, checks = 0;
   lss_note_t   q[$];
   event        look;
   always #4 clock_in = ~clock_in;
   lss_switch_ctrl dut_u (.clock_in(clock_in), .nrst_in(nrst_in), .sclk_in(sclk), .cs_n_in(cs_n),
      .si_in(si), .so_out(so), .so_oe_out(so_oe), .override_sel_in(ovr), .parallel_channel_pins_in(par),
      .pair_input_low_in(pl), .pair_input_high_in(ph), .short_fault_in(shrt), .open_fault_in(opn),
      .overvolt_in(ov), .switch_channel_pins_out(pins), .gate_out(gate), .command_out(cmd),
      .fault_status_out(fst));
   lss_host_model host_u (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so), .so_oe_in(so_oe));
   // Oldest note is judged against the output it names
   always @(look) begin
      lss_note_t n;
      n = q.pop_front();
      case (n.s)
         3'h0: `CHK({8'h00, gate}, n.v)
         3'h1: `CHK({8'h00, cmd}, n.v)
         3'h2: `CHK({8'h00, fst}, n.v)
         3'h3: `CHK(rx, n.v)
         default: `CHK({8'h00, pins}, n.v)
      endcase
   end
   task automatic expect_(input logic [2:0] s, input logic [15:0] v);
      q.push_back('{s, v});
      -> look;
      #1; // Lets the monitor re-arm before the next note
   endtask : expect_
   task automatic settle(input int n);
      repeat (n) @(negedge clock_in);
   endtask : settle
   task automatic frame(input logic [15:0] d, input int n);
      settle(4);
      host_u.xfer(d, n, rx);
      settle(10);
   endtask : frame
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   // Hang guard, far beyond the ten frames of the run
   initial begin
      #200us;
      fails++;
      tally_and_finish();
   end
   initial begin
      logic [7:0] c;
      void'($urandom(33));
      settle(6);
      nrst_in = 1'b1;
      settle(2);
      expect_(0, 16'h0000);
      expect_(1, 16'h0000);
      expect_(4, 16'h00ff);
      $display("test reset done");
      // Serial byte ORed with random parallel pins
      for (int i = 0; i < 4; i++) begin
         c = 8'($urandom());
         par = (i == 0) ? 8'hff : 8'($urandom());
         frame({8'h00, c}, 8);
         expect_(3, 16'h0000);
         expect_(1, {8'h00, c});
         expect_(0, {8'h00, par[7:6], c[5:0] | par[5:0]});
      end
      c = 8'($urandom());
      frame({c, 8'h21}, 16);
      expect_(3, {8'h00, c});
      expect_(1, 16'h0021);
      $display("test normal done");
      // Short on ch0, open on ch1 off and ch2 on
      par = 8'h01; shrt = 8'h01; opn = 8'h06;
      frame(16'h0004, 8);
      expect_(2, 16'h0003);
      expect_(0, 16'h0004);
      frame(16'h0044, 8);
      expect_(3, 16'h0003);
      expect_(2, 16'h0007);
      // Open sense on ch3 appears mid-frame and must wait for select to rise
      shrt = 8'h00; opn = 8'h00;
      fork
         frame(16'h0088, 8);
         begin
            settle(60);
            opn = 8'h08;
         end
      join
      expect_(2, 16'h0008);
      expect_(0, 16'h0009);
      frame(16'h0048, 8);
      expect_(3, 16'h0008);
      expect_(2, 16'h0000);
      shrt = 8'h00; opn = 8'h00;
      $display("test fault done");
      ovr = 1'b1; pl = 1'b1; ph = 1'b0; par = 8'($urandom());
      frame(16'h003f, 8);
      expect_(3, 16'h00ff);
      expect_(1, 16'h003f);
      expect_(0, {12'h000, {2{par[2] | par[3]}}, 2'h3});
      ovr = 1'b0;
      settle(8);
      expect_(0, {8'h00, par[7:6], 6'h3f});
      $display("test override done");
      ov = 1'b1; par = 8'hff;
      settle(8);
      expect_(0, 16'h00c0);
      $display("test overvoltage done");
      tally_and_finish();
   end
endmodule : tb_lss_switch_ctrl
